// ==== hw/bcu_pkg.sv ====
// Purpose: constants, register map and carrier types of the branch condition unit
// Assumes: 32-bit APB with byte strobes, one aligned word per register
// Notes: flag word layout follows the core's status word bit positions
package bcu_pkg;

   // ****************************************************************
   // register map (byte addresses)
   // ****************************************************************
   localparam int BCU_AW = 12;
   localparam logic [11:0] BCU_OFS_CTRL = 12'h000;
   localparam logic [11:0] BCU_OFS_FLAGS = 12'h004;
   localparam logic [11:0] BCU_OFS_COUNT = 12'h008;
   localparam logic [11:0] BCU_OFS_IP = 12'h00C;
   localparam logic [11:0] BCU_OFS_CS = 12'h010;
   localparam logic [11:0] BCU_OFS_OPERAND = 12'h014;
   localparam logic [11:0] BCU_OFS_FARSEG = 12'h018;
   localparam logic [11:0] BCU_OFS_ILEN = 12'h01C;
   localparam logic [11:0] BCU_OFS_STATUS = 12'h020;

   // ****************************************************************
   // field positions
   // ****************************************************************
   localparam int BCU_CTRL_GO = 0;
   localparam int BCU_CTRL_COND_LSB = 4;
   localparam int BCU_CTRL_FORM_LSB = 8;
   localparam int BCU_ST_TAKEN = 0;
   localparam int BCU_ST_SEGLOAD = 1;
   localparam int BCU_ST_EXECUTED = 2;

   localparam int BCU_FLG_CARRY = 0;
   localparam int BCU_FLG_PARITY = 2;
   localparam int BCU_FLG_AUX = 4;
   localparam int BCU_FLG_ZERO = 6;
   localparam int BCU_FLG_SIGN = 7;
   localparam int BCU_FLG_TRAP = 8;
   localparam int BCU_FLG_INTEN = 9;
   localparam int BCU_FLG_DIR = 10;
   localparam int BCU_FLG_OVF = 11;
   localparam logic [15:0] BCU_FLAGS_MASK = 16'h0FD5;

   // ****************************************************************
   // reset values
   // ****************************************************************
   localparam logic [15:0] BCU_RST_WORD = 16'h0000;
   localparam logic [3:0] BCU_RST_ILEN = 4'h2;
   localparam logic [15:0] BCU_COUNT_EMPTY_VAL = 16'h0000;

   // jump kinds; synonyms share one code
   typedef enum logic [3:0] {
      BCU_JUMP_IF_COUNT_EMPTY = 4'h0,
      BCU_JUMP_IF_EQUAL = 4'h1,
      BCU_JUMP_IF_GREATER = 4'h2,
      BCU_JUMP_GREATER_OR_EQUAL = 4'h3,
      BCU_JUMP_IF_LESS = 4'h4,
      BCU_JUMP_LESS_OR_EQUAL = 4'h5,
      BCU_JUMP_WITHOUT_CARRY = 4'h6,
      BCU_JUMP_IF_UNEQUAL = 4'h7,
      BCU_JUMP_WITHOUT_OVERFLOW = 4'h8,
      BCU_JUMP_IF_POSITIVE = 4'h9,
      BCU_JUMP_PARITY_ODD = 4'hA,
      BCU_JUMP_ALWAYS = 4'hB
   } bcu_cond_t;

   // target forms of the unconditional jump
   typedef enum logic [2:0] {
      BCU_FORM_SHORT = 3'h0,
      BCU_FORM_NEAR = 3'h1,
      BCU_FORM_FAR = 3'h2,
      BCU_FORM_MEMPTR_NEAR = 3'h3,
      BCU_FORM_MEMPTR_FAR = 3'h4,
      BCU_FORM_REGPTR = 3'h5
   } bcu_form_t;

   typedef struct packed {
      logic [11:0] paddr;
      logic psel;
      logic penable;
      logic pwrite;
      logic [31:0] pwdata;
      logic [3:0] pstrb;
   } bcu_apb_req_t;

   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } bcu_apb_rsp_t;

   typedef struct packed {
      logic [15:0] flags;
      logic [15:0] count;
      logic [15:0] ip;
      logic [15:0] cs;
      logic [15:0] operand;
      logic [15:0] far_seg;
      logic [3:0] ilen;
      logic [3:0] cond;
      logic [2:0] form;
      logic taken;
      logic seg_load;
      logic executed;
      logic done;
      logic [31:0] rdata;
      logic slverr;
   } bcu_state_t;

endpackage : bcu_pkg

// ==== hw/bcu_branch_unit.sv ====
// Purpose: decide short conditional and unconditional jumps and form the next ip and cs
// Assumes: APB master obeys setup/access order; one jump per write of the go bit
// Notes: flags and count are only ever written by software, never by a jump
//
// What this block does
// - count-empty jump is taken only when the 16-bit count equals zero.
// - equal and result-null jumps are taken exactly when zero flag is one.
// - greater jump taken when sign equals overflow and zero flag clear.
// - greater-or-equal jump taken when sign equals overflow, zero ignored.
// - less jump taken when sign differs from overflow.
// - less-or-equal jump taken when sign differs from overflow or zero set.
// - unconditional jump always taken; far targets load cs and ip.
// - unconditional jump takes short, near, far, memory and register targets.
// - no-carry jump taken exactly when carry flag is clear.
// - unequal and nonnull jumps taken exactly when zero flag is clear.
// - no-overflow jump taken exactly when overflow flag is clear.
// - positive jump taken exactly when sign flag is clear.
// - parity-odd and no-parity jumps taken exactly when parity flag clear.
// - taken short jump adds sign-extended 8-bit displacement to ip plus ilen.
// - no jump changes any of the nine flags.
//
// The placing of the registers and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
module bcu_branch_unit
   import bcu_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire bcu_apb_req_t apb_req,
   output bcu_apb_rsp_t apb_rsp,
   output logic [15:0] next_ip,
   output logic [15:0] next_cs,
   output logic branch_taken,
   output logic jump_done
);

   bcu_state_t s_q;
   bcu_state_t s_d;

   // ****************************************************************
   // helpers
   // ****************************************************************
   function automatic logic [15:0] merge16(input logic [15:0] old_v, input logic [31:0] wd,
                                           input logic [3:0] strb);
      logic [15:0] r;
      r = old_v;
      for (int b = 0; b < 2; b++) begin
         if (strb[b]) begin
            r[b*8 +: 8] = wd[b*8 +: 8];
         end
      end
      return r;
   endfunction : merge16

   function automatic logic cond_true(input logic [3:0] cond, input logic [15:0] fl,
                                      input logic [15:0] cnt);
      logic zf;
      logic sf;
      logic of;
      logic cf;
      logic pf;
      logic r;
      zf = fl[BCU_FLG_ZERO];
      sf = fl[BCU_FLG_SIGN];
      of = fl[BCU_FLG_OVF];
      cf = fl[BCU_FLG_CARRY];
      pf = fl[BCU_FLG_PARITY];
      case (cond)
         BCU_JUMP_IF_COUNT_EMPTY: r = (cnt == BCU_COUNT_EMPTY_VAL);
         BCU_JUMP_IF_EQUAL: r = zf;
         BCU_JUMP_IF_GREATER: r = (sf == of) && !zf;
         BCU_JUMP_GREATER_OR_EQUAL: r = (sf == of);
         BCU_JUMP_IF_LESS: r = (sf != of);
         BCU_JUMP_LESS_OR_EQUAL: r = (sf != of) || zf;
         BCU_JUMP_WITHOUT_CARRY: r = !cf;
         BCU_JUMP_IF_UNEQUAL: r = !zf;
         BCU_JUMP_WITHOUT_OVERFLOW: r = !of;
         BCU_JUMP_IF_POSITIVE: r = !sf;
         BCU_JUMP_PARITY_ODD: r = !pf;
         BCU_JUMP_ALWAYS: r = 1'b1;
         default: r = 1'b0;
      endcase
      return r;
   endfunction : cond_true

   // ****************************************************************
   // bus decode and jump execution
   // ****************************************************************
   logic setup_ph;
   logic wr_acc;
   logic go;
   logic [3:0] go_cond;
   logic [2:0] go_form;
   logic [15:0] seq_ip;
   logic [15:0] short_tgt;
   logic [15:0] near_tgt;
   logic go_taken;
   logic [31:0] ctrl_word;

   assign setup_ph = apb_req.psel && !apb_req.penable;
   assign wr_acc = apb_req.psel && apb_req.penable && apb_req.pwrite;
   assign go = wr_acc && (apb_req.paddr == BCU_OFS_CTRL) && apb_req.pstrb[0]
               && apb_req.pwdata[BCU_CTRL_GO];
   // kind comes from the write that fires the jump; form does too when pstrb[1] is set, else the stored form is used
   assign go_cond = apb_req.pstrb[0] ? apb_req.pwdata[BCU_CTRL_COND_LSB +: 4] : s_q.cond;
   assign go_form = apb_req.pstrb[1] ? apb_req.pwdata[BCU_CTRL_FORM_LSB +: 3] : s_q.form;
   // ip advanced past the jump is both the fall-through and the relative base
   assign seq_ip = s_q.ip + {12'h000, s_q.ilen};
   assign short_tgt = seq_ip + {{8{s_q.operand[7]}}, s_q.operand[7:0]};
   assign near_tgt = seq_ip + s_q.operand;
   assign go_taken = cond_true(go_cond, s_q.flags, s_q.count);
   assign ctrl_word = {21'h0, s_q.form, s_q.cond, 4'h0};

   always_comb begin
      s_d = s_q;
      s_d.done = 1'b0;

      // read data is captured in the setup cycle so that it leaves a flop
      if (setup_ph) begin
         s_d.rdata = 32'h00000000;
         s_d.slverr = 1'b0;
         if (apb_req.paddr == BCU_OFS_CTRL) begin
            s_d.rdata = ctrl_word;
         end else if (apb_req.paddr == BCU_OFS_FLAGS) begin
            s_d.rdata = {16'h0000, s_q.flags};
         end else if (apb_req.paddr == BCU_OFS_COUNT) begin
            s_d.rdata = {16'h0000, s_q.count};
         end else if (apb_req.paddr == BCU_OFS_IP) begin
            s_d.rdata = {16'h0000, s_q.ip};
         end else if (apb_req.paddr == BCU_OFS_CS) begin
            s_d.rdata = {16'h0000, s_q.cs};
         end else if (apb_req.paddr == BCU_OFS_OPERAND) begin
            s_d.rdata = {16'h0000, s_q.operand};
         end else if (apb_req.paddr == BCU_OFS_FARSEG) begin
            s_d.rdata = {16'h0000, s_q.far_seg};
         end else if (apb_req.paddr == BCU_OFS_ILEN) begin
            s_d.rdata = {28'h0, s_q.ilen};
         end else if (apb_req.paddr == BCU_OFS_STATUS) begin
            s_d.rdata = {29'h0, s_q.executed, s_q.seg_load, s_q.taken};
         end else begin
            s_d.slverr = 1'b1;
         end
      end

      if (wr_acc) begin
         if (apb_req.paddr == BCU_OFS_CTRL) begin
            s_d.cond = go_cond;
            s_d.form = go_form;
         end else if (apb_req.paddr == BCU_OFS_FLAGS) begin
            s_d.flags = merge16(s_q.flags, apb_req.pwdata, apb_req.pstrb) & BCU_FLAGS_MASK;
         end else if (apb_req.paddr == BCU_OFS_COUNT) begin
            s_d.count = merge16(s_q.count, apb_req.pwdata, apb_req.pstrb);
         end else if (apb_req.paddr == BCU_OFS_IP) begin
            s_d.ip = merge16(s_q.ip, apb_req.pwdata, apb_req.pstrb);
         end else if (apb_req.paddr == BCU_OFS_CS) begin
            s_d.cs = merge16(s_q.cs, apb_req.pwdata, apb_req.pstrb);
         end else if (apb_req.paddr == BCU_OFS_OPERAND) begin
            s_d.operand = merge16(s_q.operand, apb_req.pwdata, apb_req.pstrb);
         end else if (apb_req.paddr == BCU_OFS_FARSEG) begin
            s_d.far_seg = merge16(s_q.far_seg, apb_req.pwdata, apb_req.pstrb);
         end else if (apb_req.paddr == BCU_OFS_ILEN) begin
            if (apb_req.pstrb[0]) begin
               s_d.ilen = apb_req.pwdata[3:0];
            end
         end
      end

      // flags and count are left alone here on purpose
      if (go) begin
         s_d.executed = 1'b1;
         s_d.done = 1'b1;
         s_d.taken = go_taken;
         s_d.seg_load = 1'b0;
         s_d.ip = seq_ip;
         if (go_cond == BCU_JUMP_ALWAYS) begin
            case (go_form)
               BCU_FORM_SHORT: s_d.ip = short_tgt;
               BCU_FORM_NEAR: s_d.ip = near_tgt;
               BCU_FORM_FAR, BCU_FORM_MEMPTR_FAR: begin
                  s_d.ip = s_q.operand;
                  s_d.cs = s_q.far_seg;
                  s_d.seg_load = 1'b1;
               end
               BCU_FORM_MEMPTR_NEAR, BCU_FORM_REGPTR: s_d.ip = s_q.operand;
               default: s_d.ip = short_tgt;
            endcase
         end else if (go_taken) begin
            s_d.ip = short_tgt;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '{flags: BCU_RST_WORD, count: BCU_RST_WORD, ip: BCU_RST_WORD, cs: BCU_RST_WORD,
                  operand: BCU_RST_WORD, far_seg: BCU_RST_WORD, ilen: BCU_RST_ILEN,
                  cond: 4'h0, form: 3'h0, taken: 1'b0, seg_load: 1'b0, executed: 1'b0,
                  done: 1'b0, rdata: 32'h00000000, slverr: 1'b0};
      end else begin
         s_q <= s_d;
      end
   end

   // ****************************************************************
   // outputs
   // ****************************************************************
   // zero wait states: every access phase completes at once
   assign apb_rsp.pready = 1'b1;
   assign apb_rsp.prdata = s_q.rdata;
   assign apb_rsp.pslverr = s_q.slverr && apb_req.psel && apb_req.penable;
   assign next_ip = s_q.ip;
   assign next_cs = s_q.cs;
   assign branch_taken = s_q.taken;
   assign jump_done = s_q.done;

endmodule : bcu_branch_unit

// ==== sim/bcu_branch_unit_properties.sv ====
// Purpose: port-level checks of the branch condition unit
// Assumes: shadows of ilen and operand follow the byte strobes
// Notes: ilen and operand are shadowed from bus writes
`timescale 1ns/1ps
module bcu_branch_unit_properties
   import bcu_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire bcu_apb_req_t apb_req,
   input wire bcu_apb_rsp_t apb_rsp,
   input wire logic [15:0] next_ip,
   input wire logic [15:0] next_cs,
   input wire logic branch_taken,
   input wire logic jump_done
);
   // ****************************************************************
   // checks
   // ****************************************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic acc_w;
   logic go_w;
   logic ip_wr;
   logic [3:0] ilen_q;
   logic [15:0] op_q;
   assign acc_w = apb_req.psel && apb_req.penable && apb_req.pwrite;
   assign go_w = acc_w && apb_req.paddr == BCU_OFS_CTRL && apb_req.pstrb[0] && apb_req.pwdata[0];
   assign ip_wr = acc_w && apb_req.paddr == BCU_OFS_IP;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ilen_q <= BCU_RST_ILEN;
         op_q <= 16'h0000;
      end else begin
         if (acc_w && apb_req.paddr == BCU_OFS_ILEN && apb_req.pstrb[0]) begin
            ilen_q <= apb_req.pwdata[3:0];
         end
         if (acc_w && apb_req.paddr == BCU_OFS_OPERAND && apb_req.pstrb[0]) begin
            op_q[7:0] <= apb_req.pwdata[7:0];
         end
         if (acc_w && apb_req.paddr == BCU_OFS_OPERAND && apb_req.pstrb[1]) begin
            op_q[15:8] <= apb_req.pwdata[15:8];
         end
      end
   end
   sequence s_cond_go;
      go_w && apb_req.pwdata[7:4] <= 4'hA;
   endsequence
   sequence s_near_go;
      go_w && apb_req.pstrb[1] && !(apb_req.pwdata[7:4] == 4'hB && (apb_req.pwdata[10:8] == BCU_FORM_FAR
         || apb_req.pwdata[10:8] == BCU_FORM_MEMPTR_FAR));
   endsequence
   sequence s_pulse;
      jump_done ##1 !jump_done;
   endsequence
   chk_done_pulse: assert property (go_w |=> s_pulse) else $error("jump_done did not pulse");
   chk_done_cause: assert property (jump_done |-> $past(go_w)) else $error("jump_done without go");
   chk_always_taken: assert property (go_w && apb_req.pwdata[7:4] == 4'hB |=> branch_taken)
      else $error("unconditional jump not taken");
   chk_cs_kept: assert property (s_near_go |=> next_cs == $past(next_cs))
      else $error("cs changed on near jump");
   chk_fall_through: assert property (s_cond_go ##1 !branch_taken
      |-> next_ip == $past(next_ip) + {12'h000, ilen_q}) else $error("ip wrong after untaken jump");
   chk_rel_target: assert property (s_cond_go ##1 branch_taken
      |-> next_ip == $past(next_ip) + {12'h000, ilen_q} + {{8{op_q[7]}}, op_q[7:0]}) else $error("short target wrong");
   chk_taken_hold: assert property (!$stable(branch_taken) |-> jump_done) else $error("taken changed without jump");
   chk_ip_cause: assert property ($changed(next_ip) |-> jump_done || $past(ip_wr)) else $error("ip changed alone");
   chk_err_unmapped: assert property (apb_req.psel && apb_req.penable && apb_req.paddr > BCU_OFS_STATUS
      |-> apb_rsp.pslverr && apb_rsp.pready) else $error("unmapped access not refused");
endmodule : bcu_branch_unit_properties
bind bcu_branch_unit bcu_branch_unit_properties u_props (.pclk(pclk), .presetn(presetn), .apb_req(apb_req),
   .apb_rsp(apb_rsp), .next_ip(next_ip), .next_cs(next_cs), .branch_taken(branch_taken), .jump_done(jump_done));

// ==== sim/tb.sv ====
// Purpose: self-checking bench for the branch condition unit
// Assumes: zero-wait slave, ilen left at its reset value
// Notes: rows pack flags, count, kind, then form and taken in one nibble
`timescale 1ns/1ps
module tb;
   import bcu_pkg::*;
   typedef struct packed {
      logic [15:0] flg;
      logic [15:0] cnt;
      logic [3:0] kind;
      logic [2:0] form;
      logic tk;
   } bcu_row_t;
   localparam logic [15:0] IP0 = 16'h1000;
   localparam logic [15:0] OPND = 16'h12F0;
   localparam logic [15:0] FSEG = 16'h3456;
   localparam bcu_row_t ROWS [30] = '{
      40'h0000_0000_0_1, 40'h0000_0001_0_0, 40'h0040_0000_1_1,
      40'h0000_0000_1_0, 40'h0880_0000_2_1, 40'h08C0_0000_2_0,
      40'h0080_0000_2_0, 40'h0040_0000_3_1, 40'h0800_0000_3_0,
      40'h0080_0000_4_1, 40'h0880_0000_4_0, 40'h0040_0000_5_1,
      40'h0800_0000_5_1, 40'h0000_0000_5_0, 40'h0000_0000_6_1,
      40'h0001_0000_6_0, 40'h0000_0000_7_1, 40'h0040_0000_7_0,
      40'h0000_0000_8_1, 40'h0800_0000_8_0, 40'h0000_0000_9_1,
      40'h0080_0000_9_0, 40'h0000_0000_A_1, 40'h0004_0000_A_0,
      40'h0FD5_0000_B_1, 40'h0000_0000_B_3, 40'h0000_0000_B_5,
      40'h0000_0000_B_7, 40'h0000_0000_B_9, 40'h0000_0000_B_B};
   logic pclk = 1'h0;
   logic presetn;
   bcu_apb_req_t req;
   bcu_apb_rsp_t rsp;
   logic [15:0] next_ip;
   logic [15:0] next_cs;
   logic branch_taken;
   logic jump_done;
   int n_errors = 0;
   int samples_checked = 0;
   always #2.5 pclk = ~pclk;
   bcu_branch_unit uut (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp), .next_ip(next_ip),
      .next_cs(next_cs), .branch_taken(branch_taken), .jump_done(jump_done));
   // ****************************************************************
   // bus and compare tasks
   // ****************************************************************
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : stop_test
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d, output logic [31:0] rd,
      output logic err);
      int n;
      n = 0;
      @(posedge pclk);
      req <= '{paddr: a, psel: 1'h1, penable: 1'h0, pwrite: w, pwdata: d, pstrb: 4'hF};
      @(posedge pclk);
      req.penable <= 1'h1;
      @(posedge pclk);
      while (rsp.pready !== 1'h1 && n < 20) begin
         n++;
         @(posedge pclk);
      end
      if (n == 20) begin
         n_errors++;
         stop_test();
      end else begin
         rd = rsp.prdata;
         err = rsp.pslverr;
         req.psel <= 1'h0;
         req.penable <= 1'h0;
      end
   endtask : apb
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] rd;
      logic e;
      apb(a, 1'h1, d, rd, e);
      check("write error", 32'h0, {31'h0, e});
   endtask : wr
   task automatic rd_chk(input string what, input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] rd;
      logic e;
      apb(a, 1'h0, 32'h0, rd, e);
      check(what, exp, rd);
   endtask : rd_chk
   task automatic jump(input logic [3:0] kind, input logic [2:0] form);
      int n;
      n = 0;
      wr(BCU_OFS_CTRL, {21'h0, form, kind, 4'h1});
      do begin
         @(posedge pclk);
         n++;
      end while (jump_done !== 1'h1 && n < 8);
      if (jump_done !== 1'h1) begin
         n_errors++;
         stop_test();
      end
   endtask : jump
   // ****************************************************************
   // main sequence
   // ****************************************************************
   initial begin
      bcu_row_t r;
      logic [15:0] base;
      logic [15:0] e_ip;
      logic [15:0] e_cs;
      logic [31:0] rd;
      logic err;
      presetn = 1'h0;
      req = '0;
      repeat (4) @(posedge pclk);
      check("reset ip cs", 32'h0, {next_ip, next_cs});
      check("reset taken done", 32'h0, {30'h0, branch_taken, jump_done});
      check("reset prdata", 32'h0, rsp.prdata);
      check("reset ready err", 32'h2, {30'h0, rsp.pready, rsp.pslverr});
      presetn <= 1'h1;
      rd_chk("ilen reset", BCU_OFS_ILEN, {28'h0, BCU_RST_ILEN});
      wr(BCU_OFS_CS, 32'h2000);
      wr(BCU_OFS_OPERAND, {16'h0, OPND});
      wr(BCU_OFS_FARSEG, {16'h0, FSEG});
      e_cs = 16'h2000;
      base = IP0 + {12'h0, BCU_RST_ILEN};
      for (int i = 0; i < 30; i++) begin
         r = ROWS[i];
         wr(BCU_OFS_FLAGS, {16'h0, r.flg});
         wr(BCU_OFS_COUNT, {16'h0, r.cnt});
         wr(BCU_OFS_IP, {16'h0, IP0});
         jump(r.kind, r.form);
         if (!r.tk) e_ip = base;
         else if (r.kind != 4'hB || r.form == 3'h0) e_ip = base + {{8{OPND[7]}}, OPND[7:0]};
         else if (r.form == 3'h1) e_ip = base + OPND;
         else e_ip = OPND;
         if (r.tk && r.kind == 4'hB && (r.form == 3'h2 || r.form == 3'h4)) e_cs = FSEG;
         check("taken", {31'h0, r.tk}, {31'h0, branch_taken});
         check("next_ip", {16'h0, e_ip}, {16'h0, next_ip});
         check("next_cs", {16'h0, e_cs}, {16'h0, next_cs});
         rd_chk("flags", BCU_OFS_FLAGS, {16'h0, r.flg});
         rd_chk("count", BCU_OFS_COUNT, {16'h0, r.cnt});
         $display("row %0d done", i);
      end
      wr(BCU_OFS_STATUS, 32'h0);
      rd_chk("status", BCU_OFS_STATUS, 32'h5);
      apb(12'h024, 1'h0, 32'h0, rd, err);
      check("unmapped err", 32'h1, {31'h0, err});
      check("unmapped rdata", 32'h0, rd);
      $display("status and unmapped done");
      @(posedge pclk);
      presetn <= 1'h0;
      @(posedge pclk);
      check("mid reset ip cs", 32'h0, {next_ip, next_cs});
      check("mid reset taken done", 32'h0, {30'h0, branch_taken, jump_done});
      presetn <= 1'h1;
      jump(4'hC, 3'h0);
      check("fall through ip", 32'h0000_0002, {15'h0, branch_taken, next_ip});
      jump(4'hB, 3'h0);
      check("short from reset", 32'h0001_0004, {15'h0, branch_taken, next_ip});
      jump(4'hB, 3'h6);
      check("form six as short", 32'h0001_0006, {15'h0, branch_taken, next_ip});
      $display("reset in run done");
      stop_test();
   end
endmodule : tb
